// file: design/flyback_defs.svh
// Purpose: Constants of the flyback start-up and sensing control block
// Assumes: 20 MHz system clock; ADC results arrive as mV, uA and kOhm codes
// Notes:   Times are kept in their own unit; cycle counts derive from CLK_HZ
`ifndef FLYBACK_DEFS_SVH
`define FLYBACK_DEFS_SVH

// System clock rate
`define CLK_HZ          20000000
`define CYC_PER_US      (`CLK_HZ / 1000000)

// Observation windows for the line average
`define WIN50_US        10600
`define WIN60_US        12700
`define WIN50_CYC       (`WIN50_US * `CYC_PER_US)
`define WIN60_CYC       (`WIN60_US * `CYC_PER_US)

// Restart timers
`define RESTART_MS      200
`define FAST_MS         25
`define RESTART_CYC     (`RESTART_MS * 1000 * `CYC_PER_US)
`define FAST_CYC        (`FAST_MS * 1000 * `CYC_PER_US)

// Forced-cycle interval after gate turn-off
`define TREP_NS         52000
`define TREP_CYC        ((`TREP_NS * `CYC_PER_US) / 1000)

// Configuration pin limits in kOhm
`define CFG_MIN_KOHM    8'd27
`define CFG_MAX_KOHM    8'd68

// Line short threshold in mV
`define LINE_SHORT_MV   12'd200

// Feedback current mapping points in uA
`define FB_LOW_UA       10'd210
`define FB_HIGH_UA      10'd610

// Distortion correction ratio, negative below 4/5 of positive
`define EXT_NUM         13'd4
`define EXT_DEN         13'd5

// Reset values
`define EXT_RESET       8'h00
`define CFG_RESET       8'h00

`endif

// file: design/flyback_pkg.sv
// Purpose: Types shared by the flyback start-up and sensing control block
// Assumes: Constants come from flyback_defs.svh
// Notes:   State codes are written out
package flyback_pkg;

    // Top-level sequencing states
    typedef enum logic [2:0] {
        ST_LOCKOUT    = 3'b000,
        ST_PRE_STRONG = 3'b001,
        ST_PRE_WEAK   = 3'b010,
        ST_PRE_CHECK  = 3'b011,
        ST_SOFTSTART  = 3'b100,
        ST_RUN        = 3'b101,
        ST_RESTART    = 3'b110
    } run_state_e;

    // Line sample in mV
    typedef logic [11:0] line_mv_t;

endpackage

// file: design/flyback_startup_sense_control.sv
// Purpose: Start-up sequencing, pull-up control and sensing of a flyback controller
// Assumes: All inputs are synchronous to CLK_SYS_I; ADC codes in mV, uA, kOhm
// Notes:   Gate timing beyond turn-on requests is left to the pulse generator
`include "flyback_defs.svh"
`timescale 1ns/1ps
module flyback_startup_sense_control
    import flyback_pkg::*;
#(
    parameter int unsigned WIN50_CYCLES     = `WIN50_CYC,
    parameter int unsigned WIN60_CYCLES     = `WIN60_CYC,
    parameter int unsigned RESTART_CYCLES   = `RESTART_CYC,
    parameter int unsigned FAST_CYCLES      = `FAST_CYC,
    parameter int unsigned SOFTSTART_CYCLES = 20000,
    parameter int unsigned SETTLE_CYCLES    = 20,
    parameter int unsigned BLANK_CYCLES     = 200,
    parameter logic [11:0] BROWNIN_MV       = 12'h384,
    parameter logic [11:0] BROWNOUT_MV      = 12'h320
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // Supply comparators
    input  wire logic        SUPPLY_ON_I,
    input  wire logic        SUPPLY_WAKE_I,
    input  wire logic        SUPPLY_BURST_STOP_I,
    // Configuration pin measurement
    input  wire logic [7:0]  CFG_KOHM_I,
    input  wire logic        CFG_VALID_I,
    // Line sense
    input  wire line_mv_t    LINE_MV_I,
    input  wire logic        LINE_VALID_I,
    input  wire logic        LINE_SYNC_I,
    input  wire logic        LINE_60HZ_I,
    input  wire logic        AC_INPUT_I,
    // Start conditions and other protections
    input  wire logic        TEMP_OK_I,
    input  wire logic        PROTECT_I,
    input  wire logic        BURST_MODE_I,
    // Aux crossing sensing
    input  wire logic        AUX_ABOVE_RISE_I,
    input  wire logic        AUX_BELOW_FALL_I,
    input  wire logic        AUX_SIGNAL_OK_I,
    input  wire logic [5:0]  TARGET_VALLEY_I,
    input  wire logic        GATE_OFF_I,
    // Clamp currents
    input  wire logic [9:0]  POS_CLAMP_UA_I,
    input  wire logic [9:0]  NEG_CLAMP_UA_I,
    input  wire logic        CLAMP_VALID_I,
    // Feedback current
    input  wire logic [9:0]  FB_UA_I,
    input  wire logic        FB_RIPPLE_LARGE_I,
    // Sequencing and pull-ups
    output run_state_e       STATE_O,
    output logic             STRONG_PULLUP_O,
    output logic             WEAK_PULLUP_O,
    output logic             CFG_OK_O,
    output logic             FB_ENABLE_O,
    // Gate control
    output logic             GATE_ENABLE_O,
    output logic             GATE_ON_O,
    output logic             LOW_POWER_O,
    // Line results
    output line_mv_t         LINE_AVG_O,
    output logic             SHORT_FAULT_O,
    output logic             BROWNIN_FAULT_O,
    output logic             LINE_SYNC_EN_O,
    // Clamp and correction results
    output logic [10:0]      CLAMP_PP_O,
    output logic [13:0]      EXTENSION_O,
    output logic [7:0]       TURNON_DELAY_O,
    output logic [8:0]       POWER_LEVEL_O
);

    // True in the states that switch the power stage
    function automatic logic switching(input run_state_e s);
        switching = (s == ST_SOFTSTART) || (s == ST_RUN);
    endfunction

    run_state_e  state;
    run_state_e  next_state;
    logic [22:0] tmr;
    logic [7:0]  res_strong;
    logic [7:0]  res_weak;
    logic        avg_seen;
    logic        recharge;
    logic        sync_seen;
    logic        sync_60;
    logic [15:0] blank_cnt;
    logic        short_now;
    logic        aux_high;
    logic        cross_real;
    logic        waiting;
    logic [5:0]  valley_cnt;
    logic [11:0] since;
    logic [11:0] period;
    logic [10:0] rep_cnt;
    logic [7:0]  ext_level;
    logic [5:0]  gain;
    logic        cross_any;
    logic [5:0]  target;
    logic [17:0] win_len;
    line_mv_t    avg;
    logic        avg_valid;
    logic        start_ok;
    logic        tmr_done;
    logic        brownout;

    // Line average over the selected window
    line_window u_line_window (
        .clk_i          (CLK_SYS_I),
        .rst_n_i        (RST_N_I),
        .clear_i        (state == ST_LOCKOUT),
        .win_len_i      (win_len),
        .sample_valid_i (LINE_VALID_I),
        .sample_i       (LINE_MV_I),
        .avg_o          (avg),
        .avg_valid_o    (avg_valid)
    );

    // Window length from the last synced line frequency in ST_RUN, else the 50 Hz window
    always_comb begin
        if (state == ST_RUN && sync_seen && sync_60) begin
            win_len = 18'(WIN60_CYCLES);
        end else begin
            win_len = 18'(WIN50_CYCLES);
        end
    end

    // Last synced line frequency
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync_seen <= 1'b0;
            sync_60   <= 1'b0;
        end else if (LINE_SYNC_I && LINE_SYNC_EN_O) begin
            sync_seen <= 1'b1;
            sync_60   <= LINE_60HZ_I;
        end
    end

    // Start conditions and fault terms
    assign start_ok  = avg_seen && TEMP_OK_I && (LINE_AVG_O >= BROWNIN_MV) && CFG_OK_O
                       && !short_now;
    assign short_now = blank_cnt > 16'(BLANK_CYCLES);
    assign brownout  = avg_valid && (avg < BROWNOUT_MV);
    assign tmr_done  = (tmr == 23'h000000);

    // Sequencing state machine
    always_comb begin
        next_state = state;
        case (state)
            ST_LOCKOUT: begin
                if (SUPPLY_ON_I) begin
                    next_state = ST_PRE_STRONG;
                end
            end
            ST_PRE_STRONG: begin
                if (tmr_done && CFG_VALID_I) begin
                    next_state = ST_PRE_WEAK;
                end
            end
            ST_PRE_WEAK: begin
                if (tmr_done && CFG_VALID_I) begin
                    next_state = ST_PRE_CHECK;
                end
            end
            ST_PRE_CHECK: begin
                if (PROTECT_I) begin
                    next_state = ST_RESTART;
                end else if (start_ok) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (PROTECT_I || short_now || brownout) begin
                    next_state = ST_RESTART;
                end else if (tmr_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (PROTECT_I || short_now || brownout) begin
                    next_state = ST_RESTART;
                end
            end
            ST_RESTART: begin
                if (tmr_done && !(short_now && (LINE_AVG_O < BROWNIN_MV))) begin
                    next_state = ST_LOCKOUT;
                end
            end
            default: begin
                next_state = ST_LOCKOUT;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_LOCKOUT;
        end else begin
            state <= next_state;
        end
    end

    // Shared down-counting timer, loaded on each state entry
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tmr <= 23'h000000;
        end else if (next_state != state) begin
            case (next_state)
                ST_PRE_STRONG: tmr <= 23'(SETTLE_CYCLES);
                ST_PRE_WEAK:   tmr <= 23'(SETTLE_CYCLES);
                ST_SOFTSTART:  tmr <= 23'(SOFTSTART_CYCLES);
                ST_RESTART:    tmr <= 23'(RESTART_CYCLES);
                default:       tmr <= 23'h000000;
            endcase
        end else if (state == ST_RESTART && tmr_done) begin
            tmr <= 23'(FAST_CYCLES);
        end else if (!tmr_done) begin
            tmr <= tmr - 23'h000001;
        end
    end

    // Resistance readings with each pull-up
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            res_strong <= `CFG_RESET;
            res_weak   <= `CFG_RESET;
        end else if (tmr_done && CFG_VALID_I) begin
            if (state == ST_PRE_STRONG) begin
                res_strong <= CFG_KOHM_I;
            end
            if (state == ST_PRE_WEAK) begin
                res_weak <= CFG_KOHM_I;
            end
        end
    end

    // Supply recharge during burst pause
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            recharge <= 1'b0;
        end else if (state != ST_RUN || !BURST_MODE_I || SUPPLY_BURST_STOP_I) begin
            recharge <= 1'b0;
        end else if (SUPPLY_WAKE_I) begin
            recharge <= 1'b1;
        end
    end

    // Pull-up drive and sequencing outputs
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            STATE_O         <= ST_LOCKOUT;
            STRONG_PULLUP_O <= 1'b0;
            WEAK_PULLUP_O   <= 1'b0;
            GATE_ENABLE_O   <= 1'b0;
            LOW_POWER_O     <= 1'b1;
        end else begin
            STATE_O         <= next_state;
            STRONG_PULLUP_O <= (next_state == ST_PRE_STRONG)
                               || (switching(next_state)
                                   && !(next_state == ST_RUN && BURST_MODE_I
                                        && (recharge || SUPPLY_WAKE_I)));
            WEAK_PULLUP_O   <= (next_state == ST_PRE_WEAK);
            GATE_ENABLE_O   <= switching(next_state);
            LOW_POWER_O     <= (next_state == ST_RESTART) || (next_state == ST_LOCKOUT);
        end
    end

    // Configuration checks
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CFG_OK_O    <= 1'b0;
            FB_ENABLE_O <= 1'b0;
        end else begin
            CFG_OK_O    <= (res_weak <= `CFG_MAX_KOHM);
            FB_ENABLE_O <= (next_state == ST_RUN) && (res_strong >= `CFG_MIN_KOHM);
        end
    end

    // Latest line average
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LINE_AVG_O <= 12'h000;
            avg_seen   <= 1'b0;
        end else if (state == ST_LOCKOUT) begin
            avg_seen <= 1'b0;
        end else if (avg_valid) begin
            LINE_AVG_O <= avg;
            avg_seen   <= 1'b1;
        end
    end

    // Blanking of low line samples
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            blank_cnt <= 16'h0000;
        end else if (LINE_VALID_I) begin
            if (LINE_MV_I >= `LINE_SHORT_MV) begin
                blank_cnt <= 16'h0000;
            end else if (blank_cnt != 16'hFFFF) begin
                blank_cnt <= blank_cnt + 16'h0001;
            end
        end else if (blank_cnt != 16'h0000 && blank_cnt != 16'hFFFF) begin
            blank_cnt <= blank_cnt + 16'h0001;
        end
    end

    // Short and brownin fault flags
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SHORT_FAULT_O   <= 1'b0;
            BROWNIN_FAULT_O <= 1'b0;
        end else if (next_state == ST_SOFTSTART) begin
            SHORT_FAULT_O   <= 1'b0;
            BROWNIN_FAULT_O <= 1'b0;
        end else if (switching(state) && short_now) begin
            SHORT_FAULT_O <= 1'b1;
        end else if (state == ST_RESTART && tmr_done && short_now
                     && (LINE_AVG_O < BROWNIN_MV)) begin
            SHORT_FAULT_O   <= 1'b0;
            BROWNIN_FAULT_O <= 1'b1;
        end
    end

    // Crossing detector with hysteresis
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aux_high   <= 1'b0;
            cross_real <= 1'b0;
        end else begin
            cross_real <= aux_high && AUX_BELOW_FALL_I;
            if (AUX_ABOVE_RISE_I) begin
                aux_high <= 1'b1;
            end else if (AUX_BELOW_FALL_I) begin
                aux_high <= 1'b0;
            end
        end
    end

    // Real or extrapolated crossing
    assign cross_any = waiting && (cross_real
                       || (valley_cnt >= 6'h02 && since >= period));
    assign target    = (TARGET_VALLEY_I == 6'h00) ? 6'h01 : TARGET_VALLEY_I;

    // Valley counting, ring period and forced cycles
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            waiting    <= 1'b0;
            valley_cnt <= 6'h00;
            since      <= 12'h000;
            period     <= 12'hFFF;
            rep_cnt    <= 11'h000;
            GATE_ON_O  <= 1'b0;
        end else begin
            GATE_ON_O <= 1'b0;
            if (!GATE_ENABLE_O) begin
                waiting <= 1'b0;
            end else if (GATE_OFF_I) begin
                waiting    <= 1'b1;
                valley_cnt <= 6'h00;
                since      <= 12'h000;
                period     <= 12'hFFF;
                rep_cnt    <= 11'h000;
            end else if (waiting) begin
                rep_cnt <= rep_cnt + 11'h001;
                if (since != 12'hFFF) begin
                    since <= since + 12'h001;
                end
                if (!AUX_SIGNAL_OK_I && rep_cnt >= 11'(`TREP_CYC - 1)) begin
                    GATE_ON_O <= 1'b1;
                    waiting   <= 1'b0;
                end else if (cross_any) begin
                    valley_cnt <= valley_cnt + 6'h01;
                    since      <= 12'h000;
                    if (cross_real && valley_cnt != 6'h00) begin
                        period <= since;
                    end
                    if (valley_cnt + 6'h01 >= target) begin
                        GATE_ON_O <= 1'b1;
                        waiting   <= 1'b0;
                    end
                end
            end
        end
    end

    // Clamp sum and distortion correction level
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CLAMP_PP_O <= 11'h000;
            ext_level  <= `EXT_RESET;
        end else if (CLAMP_VALID_I) begin
            CLAMP_PP_O <= {1'b0, POS_CLAMP_UA_I} + {1'b0, NEG_CLAMP_UA_I};
            if (`EXT_DEN * {3'b000, NEG_CLAMP_UA_I} < `EXT_NUM * {3'b000, POS_CLAMP_UA_I}) begin
                if (ext_level != 8'hFF) begin
                    ext_level <= ext_level + 8'h01;
                end
            end else if (ext_level != 8'h00) begin
                ext_level <= ext_level - 8'h01;
            end
        end
    end

    // Gain from the weak-pull-up reading
    always_comb begin
        if (res_weak <= `CFG_MIN_KOHM) begin
            gain = 6'h00;
        end else if (res_weak >= `CFG_MAX_KOHM) begin
            gain = 6'(`CFG_MAX_KOHM - `CFG_MIN_KOHM);
        end else begin
            gain = 6'(res_weak - `CFG_MIN_KOHM);
        end
    end

    // Extension, turn-on delay, power mapping and sync enable
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            EXTENSION_O    <= 14'h0000;
            TURNON_DELAY_O <= 8'h00;
            POWER_LEVEL_O  <= 9'h000;
            LINE_SYNC_EN_O <= 1'b0;
        end else begin
            EXTENSION_O    <= 14'(ext_level * gain);
            TURNON_DELAY_O <= {2'b00, gain} + {2'b00, ext_level[7:2]};
            if (FB_UA_I <= `FB_LOW_UA) begin
                POWER_LEVEL_O <= 9'(`FB_HIGH_UA - `FB_LOW_UA);
            end else if (FB_UA_I >= `FB_HIGH_UA) begin
                POWER_LEVEL_O <= 9'h000;
            end else begin
                POWER_LEVEL_O <= 9'(`FB_HIGH_UA - FB_UA_I);
            end
            LINE_SYNC_EN_O <= (state == ST_RUN) && !BURST_MODE_I && AC_INPUT_I
                              && FB_RIPPLE_LARGE_I;
        end
    end

endmodule // flyback_startup_sense_control

// file: design/line_window.sv
// Purpose: Midpoint of highest and lowest line samples over one window
// Assumes: Window length in cycles is held steady by the caller
// Notes:   A clear restarts the window and drops the extrema
`timescale 1ns/1ps
module line_window
    import flyback_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        clear_i,
    input  wire logic [17:0] win_len_i,
    // Samples
    input  wire logic        sample_valid_i,
    input  wire line_mv_t    sample_i,
    // Result
    output line_mv_t         avg_o,
    output logic             avg_valid_o
);

    logic [17:0] win_cnt;
    line_mv_t    hi;
    line_mv_t    lo;
    logic        seen;
    logic [12:0] sum;

    assign sum = {1'b0, hi} + {1'b0, lo};

    // Window counter and extrema tracking
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_cnt     <= 18'h00000;
            hi          <= 12'h000;
            lo          <= 12'hFFF;
            seen        <= 1'b0;
            avg_o       <= 12'h000;
            avg_valid_o <= 1'b0;
        end else begin
            avg_valid_o <= 1'b0;
            if (clear_i) begin
                win_cnt <= 18'h00000;
                hi      <= 12'h000;
                lo      <= 12'hFFF;
                seen    <= 1'b0;
            end else if (win_cnt >= win_len_i - 18'h00001) begin
                win_cnt <= 18'h00000;
                hi      <= 12'h000;
                lo      <= 12'hFFF;
                seen    <= 1'b0;
                if (seen) begin
                    avg_o       <= sum[12:1];
                    avg_valid_o <= 1'b1;
                end
            end else begin
                win_cnt <= win_cnt + 18'h00001;
                if (sample_valid_i) begin
                    seen <= 1'b1;
                    if (sample_i > hi) begin
                        hi <= sample_i;
                    end
                    if (sample_i < lo) begin
                        lo <= sample_i;
                    end
                end
            end
        end
    end

endmodule // line_window

// file: verification/flyback_stage_model.sv
// Purpose: Start-up circuit and pin divider model
// Assumes: Pull-up outputs are registered
// Notes:   Unselected reading shows all ones
`timescale 1ns/1ps
module flyback_stage_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       strong_i,
    input  wire logic       weak_i,
    output logic            supply_on_o,
    output logic            cfg_valid_o,
    output logic [7:0]      cfg_kohm_o
);
    logic [4:0] cnt;
    // Supply charges only while the strong pull-up is off
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt <= 5'h00;
        else if (!strong_i && cnt < 5'h10) cnt <= cnt + 5'h01;
    end
    assign supply_on_o = (cnt == 5'h10);
    // Reading through whichever pull-up is on
    assign cfg_valid_o = strong_i | weak_i;
    assign cfg_kohm_o  = strong_i ? 8'h21 : (weak_i ? 8'h28 : 8'hFF);
endmodule // flyback_stage_model

// file: verification/flyback_startup_sense_control_bench.sv
// Purpose: Self-checking bench of the control block
// Assumes: Short counts set by parameters
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
module flyback_startup_sense_control_bench import flyback_pkg::*;;
    logic clk = 0, rst_n = 0, on, cv_, lv = 0, pro = 0, cv = 0, go = 0;
    logic wk = 0, bs = 0, lq = 1, sy = 0, ac = 0, bm = 0, ar = 0, af = 0, ao = 0, ls = 0;
    logic [5:0] tv = 6'h01;
    logic [7:0] k;
    logic [9:0] fb = 0, pos = 0, neg = 0;
    run_state_e st;
    logic sp, wp, ok, fe, ge, gon, lp, sf, bi, se;
    line_mv_t avg;
    logic [10:0] pp;
    logic [13:0] ext;
    logic [7:0] dly;
    logic [8:0] pwr;
    int fails = 0, n_tests = 0;
    always #25 clk = ~clk;
    // Line samples alternate between two levels
    always @(negedge clk) lv <= ~lv;
    flyback_startup_sense_control #(.WIN50_CYCLES(200), .RESTART_CYCLES(300), .FAST_CYCLES(50),
        .SOFTSTART_CYCLES(20), .BLANK_CYCLES(5)) i_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .SUPPLY_ON_I(on), .SUPPLY_WAKE_I(wk),
        .SUPPLY_BURST_STOP_I(bs), .CFG_KOHM_I(k), .CFG_VALID_I(cv_),
        .LINE_MV_I(ls ? 12'h000 : lv ? 12'h4B0 : 12'h3E8), .LINE_VALID_I(lq), .LINE_SYNC_I(sy),
        .LINE_60HZ_I(sy), .AC_INPUT_I(ac), .TEMP_OK_I(lq), .PROTECT_I(pro),
        .BURST_MODE_I(bm), .AUX_ABOVE_RISE_I(ar), .AUX_BELOW_FALL_I(af), .AUX_SIGNAL_OK_I(ao),
        .TARGET_VALLEY_I(tv), .GATE_OFF_I(go), .POS_CLAMP_UA_I(pos), .NEG_CLAMP_UA_I(neg),
        .CLAMP_VALID_I(cv), .FB_UA_I(fb), .FB_RIPPLE_LARGE_I(ac), .STATE_O(st),
        .STRONG_PULLUP_O(sp), .WEAK_PULLUP_O(wp), .CFG_OK_O(ok), .FB_ENABLE_O(fe),
        .GATE_ENABLE_O(ge), .GATE_ON_O(gon), .LOW_POWER_O(lp), .LINE_AVG_O(avg),
        .SHORT_FAULT_O(sf), .BROWNIN_FAULT_O(bi), .LINE_SYNC_EN_O(se), .CLAMP_PP_O(pp),
        .EXTENSION_O(ext), .TURNON_DELAY_O(dly), .POWER_LEVEL_O(pwr));
    flyback_stage_model i_stage (.clk_i(clk), .rst_n_i(rst_n), .strong_i(sp), .weak_i(wp),
        .supply_on_o(on), .cfg_valid_o(cv_), .cfg_kohm_o(k));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wst(input run_state_e s);
        for (int i = 0; i < 2000 && st !== s; i++) @(negedge clk);
        chk(16'(st), 16'(s));
    endtask
    task cl(input logic [9:0] p, input logic [9:0] n);
        pos = p; neg = n; cv = 1; @(negedge clk); cv = 0; @(negedge clk);
    endtask
    task pw(input logic [9:0] f, input logic [8:0] e);
        fb = f; @(negedge clk); @(negedge clk); chk(16'(pwr), 16'(e));
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Start-up, then clamp, power map, forced cycle and a fault restart
    task t_start;
        chk(16'(sp), 16'h0);
        wst(ST_PRE_STRONG); chk(16'(sp), 16'h1);
        wst(ST_PRE_WEAK); chk(16'(wp), 16'h1);
        wst(ST_SOFTSTART); chk(16'(sp), 16'h1); chk(16'(ok), 16'h1);
        wst(ST_RUN); chk(16'(fe), 16'h1); chk(16'(avg), 16'h44C);
    endtask
    task t_more;
        cl(10'h1F4, 10'h12C); chk(16'(pp), 16'h320);
        chk(16'(ext), 16'h0D); chk(16'(dly), 16'h0D);
        cl(10'h12C, 10'h12C); chk(16'(ext), 16'h00);
        pw(10'h064, 9'h190); pw(10'h0D2, 9'h190); pw(10'h19A, 9'h0C8); pw(10'h262, 9'h000);
        go = 1; @(negedge clk); go = 0;
        begin int n; for (n = 0; n < 1100 && gon !== 1'b1; n++) @(negedge clk);
            chk(16'(n), 16'd1040); end
        ao = 1; go = 1; @(negedge clk); go = 0; ar = 1; @(negedge clk); ar = 0; af = 1;
        repeat (2) @(negedge clk); chk(16'(gon), 16'h1);
        ac = 1; @(negedge clk); chk(16'(se), 16'h1); sy = 1; @(negedge clk); sy = 0;
        bm = 1; wk = 1; @(negedge clk); wk = 0; @(negedge clk); chk(16'(sp), 16'h0);
        bs = 1; repeat (2) @(negedge clk); chk(16'(sp), 16'h1); bm = 0; bs = 0;
        pro = 1; @(negedge clk); pro = 0;
        wst(ST_RESTART); chk(16'(lp), 16'h1); chk(16'(ge), 16'h0);
        wst(ST_LOCKOUT); wst(ST_RUN);
        ls = 1; wst(ST_RESTART); chk(16'(sf), 16'h1);
        repeat (320) @(negedge clk); chk(16'(bi), 16'h1); chk(16'(sf), 16'h0);
        ls = 0; wst(ST_RUN); chk(16'(bi), 16'h0);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        t_start; t_more; close_out;
    end
    initial begin #1000000; fails++; close_out; end
endmodule // flyback_startup_sense_control_bench

// file: verification/flyback_startup_sense_control_sva.sv
// Purpose: Port checks of the control block
// Assumes: One clock domain
// Notes:   Bound below
`timescale 1ns/1ps
module fssc_sva
    import flyback_pkg::*;
(
    input wire logic       CLK_SYS_I,
    input wire logic       RST_N_I,
    input wire logic       CLAMP_VALID_I,
    input wire logic [9:0] POS_CLAMP_UA_I,
    input wire logic [9:0] NEG_CLAMP_UA_I,
    input wire logic [9:0] FB_UA_I,
    input wire run_state_e STATE_O,
    input wire logic       STRONG_PULLUP_O,
    input wire logic       WEAK_PULLUP_O,
    input wire logic       FB_ENABLE_O,
    input wire logic       GATE_ENABLE_O,
    input wire logic       GATE_ON_O,
    input wire logic       LOW_POWER_O,
    input wire logic [10:0] CLAMP_PP_O,
    input wire logic [8:0] POWER_LEVEL_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    property p_lock; STATE_O == ST_LOCKOUT |-> !STRONG_PULLUP_O && !WEAK_PULLUP_O; endproperty
    a_lock: assert property (p_lock) else $error("pull-up on in lockout");
    property p_strong; STATE_O == ST_PRE_STRONG |-> STRONG_PULLUP_O && !WEAK_PULLUP_O; endproperty
    a_strong: assert property (p_strong) else $error("strong phase pull-ups");
    property p_weak; STATE_O == ST_PRE_WEAK |-> WEAK_PULLUP_O && !STRONG_PULLUP_O; endproperty
    a_weak: assert property (p_weak) else $error("weak phase pull-ups");
    property p_ss; STATE_O == ST_SOFTSTART |-> STRONG_PULLUP_O && GATE_ENABLE_O; endproperty
    a_ss: assert property (p_ss) else $error("soft start pull-up");
    property p_run; STATE_O == ST_RUN && $past(STATE_O) != ST_RUN |-> $past(STATE_O) == ST_SOFTSTART;
    endproperty
    a_run: assert property (p_run) else $error("run not from soft start");
    property p_fb; FB_ENABLE_O |-> STATE_O == ST_RUN; endproperty
    a_fb: assert property (p_fb) else $error("feedback outside run");
    property p_lp; STATE_O == ST_RESTART |-> LOW_POWER_O && !GATE_ENABLE_O; endproperty
    a_lp: assert property (p_lp) else $error("gate live in restart");
    property p_pp; CLAMP_VALID_I |=> CLAMP_PP_O ==
        {1'b0, $past(POS_CLAMP_UA_I)} + {1'b0, $past(NEG_CLAMP_UA_I)}; endproperty
    a_pp: assert property (p_pp) else $error("clamp sum wrong");
    property p_pwr; FB_UA_I <= 10'h0D2 |=> POWER_LEVEL_O == 9'h190; endproperty
    a_pwr: assert property (p_pwr) else $error("low feedback not full power");
    c_run: cover property (STATE_O == ST_RUN);
    c_rst: cover property (STATE_O == ST_RESTART);
    c_gon: cover property (GATE_ON_O);
endmodule // fssc_sva
bind flyback_startup_sense_control fssc_sva i_sva (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .CLAMP_VALID_I(CLAMP_VALID_I), .POS_CLAMP_UA_I(POS_CLAMP_UA_I),
    .NEG_CLAMP_UA_I(NEG_CLAMP_UA_I), .FB_UA_I(FB_UA_I), .STATE_O(STATE_O),
    .STRONG_PULLUP_O(STRONG_PULLUP_O), .WEAK_PULLUP_O(WEAK_PULLUP_O),
    .FB_ENABLE_O(FB_ENABLE_O), .GATE_ENABLE_O(GATE_ENABLE_O), .GATE_ON_O(GATE_ON_O),
    .LOW_POWER_O(LOW_POWER_O), .CLAMP_PP_O(CLAMP_PP_O), .POWER_LEVEL_O(POWER_LEVEL_O));
